/* File: iia_pkg.sv */
// Purpose: Shared constants, types and helpers of the index immediate ALU
// Assumes: Bit numbering is the usual little-endian; the instruction's
//          leftmost bit 0 is bit 31 here, a register's bit 0 is bit 63
// Notes: Half-word registers travel in the low 32 bits of a 64-bit word
package iia_pkg;

    // Function codes
    localparam logic [7:0] OP_ENTER_FULL = 8'h3e;
    localparam logic [7:0] OP_INC_FULL = 8'h3f;
    localparam logic [7:0] OP_ENTER_HALF = 8'h4d;
    localparam logic [7:0] OP_INC_HALF = 8'h4e;

    // Instruction field positions (little-endian bit index)
    localparam int FUNC_LSB = 24;
    localparam int DEST_LSB = 16;
    localparam int IMM_LSB = 0;
    localparam int FUNC_W = 8;
    localparam int DEST_W = 8;
    localparam int IMM_W = 16;
    localparam int INSTR_W = 32;

    // Register and index field widths
    localparam int WORD_W = 64;
    localparam int HALF_W = 32;
    localparam int FULL_IDX_W = 48;
    localparam int HALF_IDX_W = 24;

    // Values after reset
    localparam logic [63:0] WORD_RST = 64'h0;
    localparam logic [15:0] IMM_RST = 16'h0;
    localparam logic [7:0] BYTE_RST = 8'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_CALC = 4'h4,
        ST_WRITE = 4'h8
    } iia_state_t;

    typedef struct packed {
        iia_state_t state;
        logic [7:0] op;
        logic [7:0] dest;
        logic [15:0] imm;
        logic [63:0] old;
        logic [63:0] wdata;
        logic reject;
    } iia_core_t;

    function automatic logic [47:0] iia_sext48(input logic [15:0] imm);
        iia_sext48 = {{32{imm[15]}}, imm};
    endfunction : iia_sext48

    function automatic logic [23:0] iia_sext24(input logic [15:0] imm);
        iia_sext24 = {{8{imm[15]}}, imm};
    endfunction : iia_sext24

    function automatic logic iia_is_inc(input logic [7:0] op);
        iia_is_inc = (op == OP_INC_FULL) || (op == OP_INC_HALF);
    endfunction : iia_is_inc

    function automatic logic iia_is_legal(input logic [7:0] op);
        iia_is_legal = iia_is_inc(op) || (op == OP_ENTER_FULL) ||
            (op == OP_ENTER_HALF);
    endfunction : iia_is_legal

endpackage : iia_pkg

/* File: iia_calc_if.sv */
// Purpose: Carrier between the ALU sequencer and its arithmetic unit
// Assumes: Purely combinational path, one clock domain
// Notes: result is valid in the same cycle as op, imm and old
`timescale 1ns/1ps
interface iia_calc_if;
    logic [7:0] op;
    logic [15:0] imm;
    logic [63:0] old;
    logic [63:0] result;

    modport req (output op, output imm, output old, input result);
    modport unit (input op, input imm, input old, output result);
endinterface : iia_calc_if

/* File: iia_ext_add.sv */
// Purpose: Sign extension and index-field addition for the immediates
// Assumes: old holds the destination's prior content for increase ops
// Notes: Carry out of the index field is dropped on purpose
`timescale 1ns/1ps
module iia_ext_add
    import iia_pkg::*;
(
    // Operands and result
    iia_calc_if.unit calc
);

    logic [47:0] sum48;
    logic [23:0] sum24;

    // Truncating adds: wrap-around is the architected behaviour
    assign sum48 = calc.old[47:0] + iia_sext48(calc.imm);
    assign sum24 = calc.old[23:0] + iia_sext24(calc.imm);

    always_comb begin
        unique case (calc.op)
            OP_ENTER_FULL: begin
                calc.result = {16'h0, iia_sext48(calc.imm)};
            end
            OP_INC_FULL: begin
                calc.result = {calc.old[63:48], sum48};
            end
            OP_ENTER_HALF: begin
                calc.result = {40'h0, iia_sext24(calc.imm)};
            end
            OP_INC_HALF: begin
                calc.result = {32'h0, calc.old[31:24], sum24};
            end
            default: begin
                calc.result = WORD_RST;
            end
        endcase
    end

endmodule : iia_ext_add

/* File: iia_alu.sv */
// Purpose: Index immediate ALU: enter and increase with a 16-bit immediate
// Assumes: Register file read data arrives one cycle after rf_rd_en
// Notes: One instruction in flight; instr_ready is low while busy
//
// How it works
// - Full enter loads sign-extended immediate into low 48 bits of register.
// - Full enter replicates immediate sign up through destination bit 16.
// - Enter operations clear whole destination before placing the immediate.
// - Full increase replaces low 48 bits with their sum with immediate.
// - Full increase keeps the top 16 destination bits unchanged.
// - Full increase sign-extends immediate to a 48-bit addend.
// - Increase drops carry, flags no overflow, keeps truncated sum.
// - Half enter loads sign-extended immediate into low 24 of 32 bits.
// - Half enter replicates immediate sign up through destination bit 8.
// - Half increase replaces low 24 bits with their sum with immediate.
// - Half increase keeps the top 8 destination bits unchanged.
// - Half increase sign-extends immediate to a 24-bit addend.
`timescale 1ns/1ps
module iia_alu
    import iia_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Instruction handshake
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    output logic instr_ready,
    output logic op_reject,
    // Register file read
    output logic rf_rd_en,
    output logic [7:0] rf_rd_addr,
    input wire logic [63:0] rf_rd_data,
    // Register file write
    output logic rf_wr_en,
    output logic rf_wr_half,
    output logic [7:0] rf_wr_addr,
    output logic [63:0] rf_wr_data
);

    iia_core_t st_r;
    iia_core_t st_nxt;
    iia_calc_if calc ();

    logic accept;
    logic [7:0] in_func;
    logic [7:0] in_dest;
    logic [15:0] in_imm;

    // All checks run on the one clock and rest while reset is low
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    assign in_func = instr[FUNC_LSB +: FUNC_W];
    assign in_dest = instr[DEST_LSB +: DEST_W];
    assign in_imm = instr[IMM_LSB +: IMM_W];
    assign accept = instr_valid && instr_ready;

    assign calc.op = st_r.op;
    assign calc.imm = st_r.imm;
    assign calc.old = rf_rd_data;

    iia_ext_add u_ext_add (
        .calc (calc)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.reject = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                if (accept) begin
                    if (iia_is_legal(in_func)) begin
                        st_nxt.op = in_func;
                        st_nxt.dest = in_dest;
                        st_nxt.imm = in_imm;
                        // Enter never needs the old content
                        st_nxt.state = iia_is_inc(in_func) ? ST_READ : ST_CALC;
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                end
            end
            ST_READ: begin
                st_nxt.state = ST_CALC;
            end
            ST_CALC: begin
                st_nxt.old = rf_rd_data;
                st_nxt.wdata = calc.result;
                st_nxt.state = ST_WRITE;
            end
            ST_WRITE: begin
                st_nxt.state = ST_IDLE;
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.state <= ST_IDLE;
            st_r.op <= BYTE_RST;
            st_r.dest <= BYTE_RST;
            st_r.imm <= IMM_RST;
            st_r.old <= WORD_RST;
            st_r.wdata <= WORD_RST;
            st_r.reject <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign instr_ready = (st_r.state == ST_IDLE);
    assign op_reject = st_r.reject;
    assign rf_rd_en = (st_r.state == ST_READ);
    assign rf_rd_addr = st_r.dest;
    assign rf_wr_en = (st_r.state == ST_WRITE);
    assign rf_wr_half = (st_r.op == OP_ENTER_HALF) || (st_r.op == OP_INC_HALF);
    assign rf_wr_addr = st_r.dest;
    assign rf_wr_data = st_r.wdata;

    // Checks
    sequence inc_path_s;
        rf_rd_en ##1 (st_r.state == ST_CALC) ##1 rf_wr_en;
    endsequence

    sequence enter_path_s;
        (st_r.state == ST_CALC) && !rf_rd_en ##1 rf_wr_en;
    endsequence

    sequence wr_of_s(logic [7:0] code);
        rf_wr_en && (st_r.op == code);
    endsequence

    full_enter_a: assert property (
        rf_wr_en && st_r.op == OP_ENTER_FULL |->
        rf_wr_data[47:0] == iia_sext48(st_r.imm))
        else $error("full enter low 48 bits wrong");

    full_sign_a: assert property (
        rf_wr_en && st_r.op == OP_ENTER_FULL |->
        rf_wr_data[47:16] == {32{st_r.imm[15]}})
        else $error("full enter sign not replicated");

    enter_clear_a: assert property (
        rf_wr_en && !iia_is_inc(st_r.op) |->
        rf_wr_data[63:48] == 16'h0 && (!rf_wr_half ||
        rf_wr_data[63:24] == 40'h0))
        else $error("enter left stale bits");

    full_sum_a: assert property (
        rf_wr_en && st_r.op == OP_INC_FULL |->
        rf_wr_data[47:0] == 48'(st_r.old[47:0] + iia_sext48(st_r.imm)))
        else $error("full increase sum wrong");

    // The top bits must match what the file handed over in CALC
    full_keep_a: assert property (
        st_r.state == ST_CALC && st_r.op == OP_INC_FULL |=>
        rf_wr_data[63:48] == $past(rf_rd_data[63:48]))
        else $error("full increase changed top bits");

    // Increase walks read, calc and write, then frees the port
    inc_flow_a: assert property (
        accept && iia_is_inc(in_func) |=> inc_path_s ##1 instr_ready &&
        !op_reject)
        else $error("increase did not complete as a plain write");

    enter_flow_a: assert property (
        accept && iia_is_legal(in_func) && !iia_is_inc(in_func) |=>
        enter_path_s)
        else $error("enter did not write two cycles after accept");

    half_enter_a: assert property (
        wr_of_s(OP_ENTER_HALF) |-> rf_wr_data[23:0] ==
        iia_sext24(st_r.imm) && rf_wr_half)
        else $error("half enter low 24 bits wrong");

    half_sign_a: assert property (
        wr_of_s(OP_ENTER_HALF) |->
        rf_wr_data[23:16] == {8{st_r.imm[15]}})
        else $error("half enter sign not replicated");

    half_sum_a: assert property (
        wr_of_s(OP_INC_HALF) |-> rf_wr_data[23:0] ==
        24'(st_r.old[23:0] + iia_sext24(st_r.imm)))
        else $error("half increase sum wrong");

    half_keep_a: assert property (
        wr_of_s(OP_INC_HALF) |->
        rf_wr_data[31:24] == st_r.old[31:24])
        else $error("half increase changed top bits");

    decode_a: assert property (
        accept && iia_is_legal(in_func) |=> st_r.op == $past(in_func) &&
        rf_wr_addr == $past(in_dest) && st_r.imm == $past(in_imm))
        else $error("instruction fields decoded wrongly");

    // Unknown codes bounce at once and never reach the register file
    reject_flow_a: assert property (
        accept && !iia_is_legal(in_func) |=>
        op_reject && instr_ready && !rf_rd_en && !rf_wr_en)
        else $error("unknown code not rejected cleanly");

    // A reject costs no busy cycle
    reject_ready_a: assert property (
        op_reject |-> instr_ready && !rf_wr_en)
        else $error("reject cost a busy cycle");

    half_top_a: assert property (
        rf_wr_en && rf_wr_half |-> rf_wr_data[63:32] == 32'h0)
        else $error("half write touched the upper word");

    // Increase must write back the very register that it read
    same_reg_a: assert property (
        rf_rd_en |=> ##1 rf_wr_en && rf_wr_addr == $past(rf_rd_addr, 2))
        else $error("increase wrote another register");

    // Single-cycle strobes keep the file from taking a result twice
    wr_pulse_a: assert property (
        rf_wr_en |=> !rf_wr_en && !rf_rd_en && instr_ready)
        else $error("write strobe longer than one cycle");

endmodule : iia_alu

/* File: tb_top.sv */
// Purpose: Self-checking bench for the index immediate ALU
// Assumes: Bench plays the register file; read data in the cycle after
//          rf_rd_en, random junk at every other time
// Notes: Expected results go into a queue at the accept edge
`timescale 1ns/1ps
module tb_top
    import iia_pkg::*;
;

    typedef struct packed {
        logic rej;
        logic half;
        logic [7:0] addr;
        logic [63:0] data;
        int unsigned due;
    } iia_tb_exp_t;

    logic ref_clk;
    logic rst_n;
    logic instr_valid;
    logic [31:0] instr;
    logic instr_ready;
    logic op_reject;
    logic rf_rd_en;
    logic [7:0] rf_rd_addr;
    logic [63:0] rf_rd_data;
    logic rf_wr_en;
    logic rf_wr_half;
    logic [7:0] rf_wr_addr;
    logic [63:0] rf_wr_data;
    logic [63:0] rf [256];
    logic [63:0] shadow [256];
    logic [7:0] ops [4] = '{OP_INC_FULL, OP_INC_HALF, OP_ENTER_FULL,
        OP_ENTER_HALF};
    logic [15:0] imms [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
    iia_tb_exp_t exq [$];
    int err_count;
    int n_checks;
    int unsigned cyc;
    int seed;
    logic rd_seen;
    logic [7:0] code;

    iia_alu u_iia_alu (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .op_reject(op_reject),
        .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
        .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
        .rf_wr_half(rf_wr_half), .rf_wr_addr(rf_wr_addr),
        .rf_wr_data(rf_wr_data));

    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic issue(input logic [7:0] op, input logic [7:0] dest,
        input logic [15:0] imm);
        iia_tb_exp_t e;
        logic [63:0] o;
        logic [47:0] s48;
        logic [23:0] s24;
        int n;
        o = shadow[dest];
        s48 = {{32{imm[15]}}, imm};
        s24 = {{8{imm[15]}}, imm};
        e = '0;
        e.addr = dest;
        e.half = (op == OP_ENTER_HALF) || (op == OP_INC_HALF);
        e.due = 3;
        case (op)
            OP_ENTER_FULL: begin e.data = {16'h0, s48}; e.due = 2; end
            OP_INC_FULL: e.data = {o[63:48], o[47:0] + s48};
            OP_ENTER_HALF: begin e.data = {40'h0, s24}; e.due = 2; end
            OP_INC_HALF: e.data = {32'h0, o[31:24], o[23:0] + s24};
            default: begin e.rej = 1'b1; e.due = 1; end
        endcase
        if (!e.rej) shadow[dest] = e.data;
        instr = {op, dest, imm};
        instr_valid = 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (instr_ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 20) check("instr_ready", 64'h0, 64'h1);
        e.due = e.due + cyc;
        exq.push_back(e);
        #1;
    endtask : issue

    // Register file: reads are valid only in the cycle after the strobe
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        rd_seen = rf_rd_en;
        if (rf_wr_en === 1'b1) rf[rf_wr_addr] = rf_wr_data;
        #1;
        if (rd_seen === 1'b1) rf_rd_data = rf[rf_rd_addr];
        else rf_rd_data = {$random(seed), $random(seed)};
    end

    always @(posedge ref_clk) begin : mon
        iia_tb_exp_t e;
        if (rst_n === 1'b1 && rf_rd_en === 1'b1 && exq.size() > 0) begin
            check("rf_rd_addr", 64'(rf_rd_addr), 64'(exq[0].addr));
            check("read cycle", 64'(cyc), 64'(exq[0].due - 2));
        end
        if (rst_n === 1'b1 && (rf_wr_en === 1'b1 || op_reject === 1'b1)) begin
            if (exq.size() == 0) begin
                check("stray result", 64'h1, 64'h0);
            end else begin
                e = exq.pop_front();
                check("op_reject", 64'(op_reject), 64'(e.rej));
                check("rf_wr_en", 64'(rf_wr_en), 64'(!e.rej));
                check("result cycle", 64'(cyc), 64'(e.due));
                if (!e.rej) begin
                    check("rf_wr_addr", 64'(rf_wr_addr), 64'(e.addr));
                    check("rf_wr_half", 64'(rf_wr_half), 64'(e.half));
                    check("rf_wr_data", rf_wr_data, e.data);
                    check("rf_wr_data", rf_wr_data, e.data);
                    check("rf_wr_data", rf_wr_data, e.data);
                    if (e.half) check("half data", rf_wr_data, e.data);
                end
            end
        end
    end

    initial begin
        #(25 * 20000);
        err_count++;
        tally_and_finish();
    end

    initial begin
        seed = 32'hab66;
        ref_clk = 1'b0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 32'h0;
        rf_rd_data = 64'h0;
        cyc = 0;
        for (int i = 0; i < 256; i++) begin
            rf[i] = {$random(seed), $random(seed)};
            shadow[i] = rf[i];
        end
        // Index fields all ones, so that +1 wraps and the carry must vanish
        rf[1] = 64'hffff_ffff_ffff_ffff;
        rf[2] = 64'h1234_5678_a5ff_ffff;
        shadow[1] = rf[1];
        shadow[2] = rf[2];
        repeat (20) @(posedge ref_clk);
        check("reset ready", 64'(instr_ready), 64'h1);
        check("reset strobes", 64'({op_reject, rf_rd_en, rf_wr_en}), 64'h0);
        #1 rst_n = 1'b1;
        issue(OP_INC_FULL, 8'h01, 16'h0001);
        issue(OP_INC_HALF, 8'h02, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                issue(ops[(i + 2) % 4], 8'h03, imms[j]);
                issue(ops[i], 8'h03, imms[3 - j]);
            end
        end
        // Random mix; unknown codes come back to back with what follows unless a 3-cycle idle gap is drawn
        for (int k = 0; k < 80; k++) begin
            code = ops[$unsigned($random(seed)) % 4];
            if (($random(seed) & 7) == 0) begin
                code = 8'($random(seed));
                if (code == 8'h3e || code == 8'h3f) code = 8'h10;
                if (code == 8'h4d || code == 8'h4e) code = 8'h11;
            end
            issue(code, 8'($unsigned($random(seed)) % 6),
                (($random(seed) & 3) == 0) ? imms[k % 4] : 16'($random(seed)));
            if (($random(seed) & 3) == 0) begin
                instr_valid = 1'b0;
                instr = $random(seed);
                repeat (3) @(posedge ref_clk);
                #1;
            end
        end
        instr_valid = 1'b0;
        repeat (10) @(posedge ref_clk);
        check("pending results", 64'(exq.size()), 64'h0);
        tally_and_finish();
    end
endmodule : tb_top
